//--- core/fmcd_pkg.sv
// Constants and types shared by the flash misc command decoder
package fmcd_pkg;

	// Command codes
	localparam logic [7:0] OP_ADDR4_ENTER = 8'hB7;
	localparam logic [7:0] OP_ADDR4_EXIT  = 8'hE9;
	localparam logic [7:0] OP_PD_ENTER    = 8'hB9;
	localparam logic [7:0] OP_PD_EXIT     = 8'hAB;
	localparam logic [7:0] OP_QUAD_ENTER  = 8'h35;
	localparam logic [7:0] OP_QUAD_EXIT   = 8'hF5;
	localparam logic [7:0] OP_WR_ENABLE   = 8'h06;
	localparam logic [7:0] OP_WR_DISABLE  = 8'h04;
	localparam logic [7:0] OP_OTP_READ    = 8'h4B;
	localparam logic [7:0] OP_OTP_PROG    = 8'h42;
	localparam logic [7:0] OP_VLK_READ    = 8'hE8;
	localparam logic [7:0] OP_VLK_WRITE   = 8'hE5;
	localparam logic [7:0] OP_NVLK_READ   = 8'hE2;
	localparam logic [7:0] OP_NVLK_PROG   = 8'hE3;
	localparam logic [7:0] OP_NVLK_ERASE  = 8'hE4;
	localparam logic [7:0] OP_FRZ_READ    = 8'hA7;
	localparam logic [7:0] OP_FRZ_SET     = 8'hA6;
	localparam logic [7:0] OP_GPR_READ    = 8'h96;
	localparam logic [7:0] OP_DISC_READ   = 8'h5A;

	// Framing
	localparam logic [2:0] ADDR_BYTES3     = 3'h3;
	localparam logic [2:0] ADDR_BYTES4     = 3'h4;
	localparam logic [3:0] DUMMY_FACT_STD  = 4'h8;
	localparam logic [3:0] DUMMY_FACT_QUAD = 4'hA;
	localparam logic [3:0] DUMMY_GPR       = 4'h8;
	localparam logic [3:0] DUMMY_DISC      = 4'h8;
	localparam logic [3:0] DUMMY_CFG_FACT  = 4'h0;
	localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
	localparam logic [6:0] GPR_BYTES       = 7'h40;
	localparam logic [6:0] CNT_MAX         = 7'h7F;
	localparam logic [7:0] BYTE_ZERO       = 8'h00;
	localparam int         SECT_SHIFT      = 16;

	// Line counts and the pins driven for each
	localparam logic [2:0] LINES_1   = 3'h1;
	localparam logic [2:0] LINES_2   = 3'h2;
	localparam logic [2:0] LINES_4   = 3'h4;
	localparam logic [3:0] OE_MASK_1 = 4'h2;
	localparam logic [3:0] OE_MASK_2 = 4'h3;
	localparam logic [3:0] OE_MASK_4 = 4'hF;

	// Width of the mode word carried into the link domain
	localparam int LINK_SYNC_W = 11;

	typedef enum logic [2:0] {
		ST_CMD    = 3'b000,
		ST_ADDR   = 3'b001,
		ST_DUMMY  = 3'b011,
		ST_DATA   = 3'b010,
		ST_IGNORE = 3'b110
	} fmcd_state_e;

endpackage : fmcd_pkg

//--- core/fmcd_sync.sv
// Two-stage synchroniser for levels and toggles
`timescale 1ns/100ps
module fmcd_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);

	logic [W-1:0] meta_q;

	// First stage feeds only the second
	always_ff @(posedge clk_in) begin
		meta_q <= d_in;
		q_out  <= meta_q;
	end

endmodule : fmcd_sync

//--- core/fmcd_decoder.sv
// Command decoder for mode, power-down, quad and sector lock commands
`timescale 1ns/100ps
// How it works
// - B7h, command only, selects four-byte addressing in every protocol.
// - E9h, command only, returns to three-byte addressing.
// - B9h, command only, enters deep power-down.
// - ABh, command only, leaves deep power-down.
// - 35h, command only, selects the quad protocol.
// - F5h, command only, leaves the quad protocol.
// - OTP read dummies default to 8, or 10 in quad; configurable.
// - E8h takes 3 or 4 address bytes, no dummies, streams lock data.
// - E2h always takes four address bytes, then streams lock data.
// - A7h reads freeze bit, single-line extended protocol only.
// - Command uses 1, 2 or 4 lines by protocol; phases per triple.
// - Three-or-four address commands take four bytes in four-byte mode.
// - General-purpose register read always uses 8 dummy cycles.
// - After 64 register bytes output 00h forever, no wrap.
// - Discovery read always takes three address bytes.
module fmcd_decoder import fmcd_pkg::*; #(
	parameter int NUM_SECT = 16
) (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       sclk_in,
	input  wire logic       cs_n_in,
	input  wire logic [3:0] serial_data_lines_in,
	output logic      [3:0] serial_data_lines_out,
	output logic      [3:0] serial_data_lines_oe_out,
	input  wire logic       dual_mode_in,
	input  wire logic [3:0] dummy_cfg_in,
	output logic            four_byte_out,
	output logic            quad_mode_out,
	output logic            deep_pd_out,
	output logic            freeze_out,
	output logic            write_en_out
);

	localparam int SW = (NUM_SECT > 1) ? $clog2(NUM_SECT) : 1;

	// Core domain state
	logic        four_q;
	logic        quad_q;
	logic        dpd_q;
	logic        frz_q;
	logic        wel_q;
	logic        ev_tgl_s;
	logic        ev_seen_q;
	logic        ev_fire;
	logic [7:0]  ev_code;

	// Link domain state
	fmcd_state_e st_q;
	fmcd_state_e st_d;
	logic [7:0]  op_q;
	logic [7:0]  op_d;
	logic [7:0]  sh_q;
	logic [7:0]  byte_d;
	logic [2:0]  bit_q;
	logic [6:0]  cnt_q;
	logic [6:0]  cnt_d;
	logic [2:0]  alen_q;
	logic [2:0]  alen_d;
	logic [3:0]  dum_q;
	logic [3:0]  dum_d;
	logic [3:0]  otp_dum;
	logic [31:0] addr_q;
	logic [31:0] addr_d;
	logic [7:0]  out_q;
	logic [7:0]  out_d;
	logic [7:0]  rd_byte;
	logic [3:0]  dq_o_q;
	logic [3:0]  dq_oe_q;
	logic [2:0]  lw;
	logic        byte_done;
	logic        load;
	logic        fire;
	logic        rd_d;
	logic        wr_op;
	logic [SW-1:0] sect;
	logic        vlk_we;
	logic        nvl_we;
	logic        nvl_clr;
	logic        vlk_q [NUM_SECT];
	logic        nvl_q [NUM_SECT];
	logic        ev_tgl_q;
	logic [7:0]  ev_op_q;

	// Mode word as seen by the link domain
	logic [LINK_SYNC_W-1:0] lm;
	logic        lrst;
	logic        dual_l;
	logic        quad_l;
	logic        four_l;
	logic        dpd_l;
	logic        frz_l;
	logic        wel_l;
	logic [3:0]  dummy_l;

	fmcd_sync #(.W(LINK_SYNC_W)) u_link_sync (
		.clk_in (sclk_in),
		.d_in   ({rst_in, dual_mode_in, quad_q, four_q, dpd_q, frz_q,
		          wel_q, dummy_cfg_in}),
		.q_out  (lm)
	);

	assign lrst    = lm[10];
	assign dual_l  = lm[9];
	assign quad_l  = lm[8];
	assign four_l  = lm[7];
	assign dpd_l   = lm[6];
	assign frz_l   = lm[5];
	assign wel_l   = lm[4];
	assign dummy_l = lm[3:0];

	fmcd_sync #(.W(1)) u_ev_sync (
		.clk_in (clk_in),
		.d_in   (ev_tgl_q),
		.q_out  (ev_tgl_s)
	);

	// Opcode is held until the next event, so reading it here is safe
	assign ev_fire = ev_tgl_s ^ ev_seen_q;
	assign ev_code = ev_op_q;

	always_comb begin
		lw = quad_l ? LINES_4 : (dual_l ? LINES_2 : LINES_1);
		if (quad_l) begin
			byte_d = {sh_q[3:0], serial_data_lines_in};
		end else if (dual_l) begin
			byte_d = {sh_q[5:0], serial_data_lines_in[1:0]};
		end else begin
			byte_d = {sh_q[6:0], serial_data_lines_in[0]};
		end
		byte_done = ({1'b0, bit_q} + {1'b0, lw}) == BITS_PER_BYTE;
		st_d    = st_q;
		op_d    = op_q;
		alen_d  = alen_q;
		dum_d   = dum_q;
		addr_d  = addr_q;
		cnt_d   = cnt_q;
		load    = 1'b0;
		fire    = 1'b0;
		wr_op   = (op_q == OP_VLK_WRITE) || (op_q == OP_OTP_PROG);
		otp_dum = (dummy_l == DUMMY_CFG_FACT) ?
			(quad_l ? DUMMY_FACT_QUAD : DUMMY_FACT_STD) : dummy_l;
		unique case (st_q)
			ST_CMD: if (byte_done) begin
				op_d   = byte_d;
				cnt_d  = '0;
				alen_d = four_l ? ADDR_BYTES4 : ADDR_BYTES3;
				st_d   = ST_IGNORE;
				// Asleep, only the wake code is heard
				if (!dpd_l || byte_d == OP_PD_EXIT) begin
					case (byte_d)
						OP_ADDR4_ENTER, OP_ADDR4_EXIT, OP_PD_ENTER,
						OP_PD_EXIT, OP_QUAD_ENTER, OP_QUAD_EXIT,
						OP_WR_ENABLE, OP_WR_DISABLE: begin
							fire = 1'b1;
						end
						OP_FRZ_SET: begin
							fire = wel_l;
						end
						OP_NVLK_ERASE: begin
							fire = wel_l && !frz_l;
						end
						OP_VLK_READ, OP_VLK_WRITE, OP_OTP_READ,
						OP_OTP_PROG: begin
							st_d = ST_ADDR;
						end
						OP_NVLK_READ, OP_NVLK_PROG: begin
							alen_d = ADDR_BYTES4;
							st_d   = ST_ADDR;
						end
						OP_DISC_READ: begin
							alen_d = ADDR_BYTES3;
							st_d   = ST_ADDR;
						end
						OP_GPR_READ: begin
							dum_d = DUMMY_GPR;
							st_d  = ST_DUMMY;
						end
						OP_FRZ_READ: begin
							if (lw == LINES_1) begin
								st_d = ST_DATA;
								load = 1'b1;
							end
						end
						default: begin
						end
					endcase
				end
			end
			ST_ADDR: if (byte_done) begin
				addr_d = {addr_q[23:0], byte_d};
				cnt_d  = cnt_q + 7'h1;
				if (cnt_q == {4'h0, alen_q} - 7'h1) begin
					cnt_d = '0;
					case (op_q)
						OP_VLK_READ, OP_NVLK_READ: begin
							st_d = ST_DATA;
							load = 1'b1;
						end
						OP_DISC_READ: begin
							dum_d = DUMMY_DISC;
							st_d  = ST_DUMMY;
						end
						OP_OTP_READ: begin
							dum_d = otp_dum;
							st_d  = ST_DUMMY;
						end
						OP_VLK_WRITE, OP_OTP_PROG: begin
							st_d = ST_DATA;
						end
						OP_NVLK_PROG: begin
							fire = wel_l && !frz_l;
							st_d = ST_IGNORE;
						end
						default: begin
							st_d = ST_IGNORE;
						end
					endcase
				end
			end
			ST_DUMMY: begin
				cnt_d = cnt_q + 7'h1;
				if (cnt_q == {3'h0, dum_q} - 7'h1) begin
					cnt_d = '0;
					st_d  = ST_DATA;
					load  = 1'b1;
				end
			end
			ST_DATA: if (byte_done) begin
				if (wr_op) begin
					// One data byte only; the rest is dropped
					fire = wel_l && (op_q == OP_OTP_PROG || !frz_l);
					st_d = ST_IGNORE;
				end else begin
					load = 1'b1;
					if (cnt_q != CNT_MAX) begin
						cnt_d = cnt_q + 7'h1;
					end
				end
			end
			ST_IGNORE: begin
			end
			default: begin
				st_d = ST_IGNORE;
			end
		endcase
		sect    = addr_d[SECT_SHIFT +: SW];
		vlk_we  = fire && (op_d == OP_VLK_WRITE);
		nvl_we  = fire && (op_d == OP_NVLK_PROG);
		nvl_clr = fire && (op_d == OP_NVLK_ERASE);
		rd_byte = BYTE_ZERO;
		case (op_d)
			OP_VLK_READ:  rd_byte[0] = vlk_q[sect];
			OP_NVLK_READ: rd_byte[0] = nvl_q[sect];
			OP_FRZ_READ:  rd_byte[0] = frz_l;
			OP_GPR_READ: begin
				// Counter saturates, so no wrap past the end
				if (cnt_d < GPR_BYTES) begin
					rd_byte = {1'b0, cnt_d};
				end
			end
			default: begin
			end
		endcase
		rd_d  = (st_d == ST_DATA) && (op_d != OP_VLK_WRITE) &&
			(op_d != OP_OTP_PROG);
		out_d = load ? rd_byte : (out_q << lw);
	end

	// Frame logic; select high clears it without any clock edge
	always_ff @(posedge sclk_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			st_q   <= ST_CMD;
			op_q   <= BYTE_ZERO;
			sh_q   <= BYTE_ZERO;
			bit_q  <= '0;
			cnt_q  <= '0;
			alen_q <= ADDR_BYTES3;
			dum_q  <= DUMMY_FACT_STD;
			addr_q <= '0;
		end else begin
			st_q   <= st_d;
			op_q   <= op_d;
			sh_q   <= byte_d;
			bit_q  <= (st_q == ST_DUMMY) ? 3'h0 : bit_q + lw;
			cnt_q  <= cnt_d;
			alen_q <= alen_d;
			dum_q  <= dum_d;
			addr_q <= addr_d;
		end
	end

	// Read data out, updated on the rising edge for the next one
	always_ff @(posedge sclk_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			out_q   <= BYTE_ZERO;
			dq_o_q  <= '0;
			dq_oe_q <= '0;
		end else begin
			out_q <= out_d;
			if (quad_l) begin
				dq_o_q  <= out_d[7:4];
				dq_oe_q <= rd_d ? OE_MASK_4 : 4'h0;
			end else if (dual_l) begin
				dq_o_q  <= {2'b00, out_d[7:6]};
				dq_oe_q <= rd_d ? OE_MASK_2 : 4'h0;
			end else begin
				dq_o_q  <= {2'b00, out_d[7], 1'b0};
				dq_oe_q <= rd_d ? OE_MASK_1 : 4'h0;
			end
		end
	end

	assign serial_data_lines_out    = dq_o_q;
	assign serial_data_lines_oe_out = dq_oe_q;

	// Event to the core domain survives the end of the frame
	always_ff @(posedge sclk_in) begin
		if (lrst) begin
			ev_tgl_q <= 1'b0;
			ev_op_q  <= BYTE_ZERO;
		end else if (fire && !cs_n_in) begin
			ev_tgl_q <= ~ev_tgl_q;
			ev_op_q  <= op_d;
		end
	end

	// Per-sector lock bits live beside the link for zero-latency reads
	genvar g;
	generate
		for (g = 0; g < NUM_SECT; g++) begin : g_lock
			always_ff @(posedge sclk_in) begin
				if (lrst) begin
					vlk_q[g] <= 1'b0;
					nvl_q[g] <= 1'b0;
				end else if (!cs_n_in) begin
					if (vlk_we && sect == SW'(g)) begin
						vlk_q[g] <= byte_d[0];
					end
					if (nvl_clr) begin
						nvl_q[g] <= 1'b0;
					end else if (nvl_we && sect == SW'(g)) begin
						nvl_q[g] <= 1'b1;
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ev_seen_q <= 1'b0;
		end else begin
			ev_seen_q <= ev_tgl_s;
		end
	end

	// Address width
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			four_q <= 1'b0;
		end else if (ev_fire && ev_code == OP_ADDR4_ENTER) begin
			four_q <= 1'b1;
		end else if (ev_fire && ev_code == OP_ADDR4_EXIT) begin
			four_q <= 1'b0;
		end
	end

	// Protocol and power
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			quad_q <= 1'b0;
			dpd_q  <= 1'b0;
		end else if (ev_fire) begin
			if (ev_code == OP_QUAD_ENTER) begin
				quad_q <= 1'b1;
			end else if (ev_code == OP_QUAD_EXIT) begin
				quad_q <= 1'b0;
			end
			if (ev_code == OP_PD_ENTER) begin
				dpd_q <= 1'b1;
			end else if (ev_code == OP_PD_EXIT) begin
				dpd_q <= 1'b0;
			end
		end
	end

	// Write enable latch is used up by each executed write
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wel_q <= 1'b0;
			frz_q <= 1'b0;
		end else if (ev_fire) begin
			if (ev_code == OP_WR_ENABLE) begin
				wel_q <= 1'b1;
			end else if (ev_code == OP_WR_DISABLE ||
				ev_code == OP_FRZ_SET || ev_code == OP_VLK_WRITE ||
				ev_code == OP_NVLK_PROG || ev_code == OP_NVLK_ERASE ||
				ev_code == OP_OTP_PROG) begin
				wel_q <= 1'b0;
			end
			if (ev_code == OP_FRZ_SET) begin
				frz_q <= 1'b1;
			end
		end
	end

	assign four_byte_out = four_q;
	assign quad_mode_out = quad_q;
	assign deep_pd_out   = dpd_q;
	assign freeze_out    = frz_q;
	assign write_en_out  = wel_q;

	sequence s_evt(logic [7:0] c);
		ev_fire && ev_code == c;
	endsequence

	sequence s_ignoring;
		st_q == ST_IGNORE && dq_oe_q == 4'h0;
	endsequence

	property p_addr4_on;
		@(posedge clk_in) disable iff (rst_in)
		s_evt(OP_ADDR4_ENTER) |=> four_q;
	endproperty
	a_addr4_on: assert property (p_addr4_on)
		else $error("four-byte mode not entered");

	property p_addr4_off;
		@(posedge clk_in) disable iff (rst_in)
		s_evt(OP_ADDR4_EXIT) |=> !four_q && $past(ev_fire);
	endproperty
	a_addr4_off: assert property (p_addr4_off)
		else $error("four-byte mode not left");

	property p_pd;
		@(posedge clk_in) disable iff (rst_in)
		s_evt(OP_PD_ENTER) |=> dpd_q && deep_pd_out;
	endproperty
	a_pd: assert property (p_pd)
		else $error("deep power-down not entered");

	property p_pd_exit;
		@(posedge clk_in) disable iff (rst_in)
		s_evt(OP_PD_EXIT) |=> !deep_pd_out;
	endproperty
	a_pd_exit: assert property (p_pd_exit)
		else $error("deep power-down not left");

	property p_quad;
		@(posedge clk_in) disable iff (rst_in)
		s_evt(OP_QUAD_ENTER) |=> quad_mode_out;
	endproperty
	a_quad: assert property (p_quad)
		else $error("quad protocol not entered");

	property p_quad_off;
		@(posedge clk_in) disable iff (rst_in)
		s_evt(OP_QUAD_EXIT) |=> $fell(quad_q) || !$past(quad_q);
	endproperty
	a_quad_off: assert property (p_quad_off)
		else $error("quad protocol not left");

	property p_otp_dummy;
		@(posedge sclk_in) disable iff (cs_n_in)
		(st_q == ST_DUMMY && op_q == OP_OTP_READ &&
		 dummy_l == DUMMY_CFG_FACT && $stable(dummy_l)) |->
		dum_q == (quad_l ? DUMMY_FACT_QUAD : DUMMY_FACT_STD);
	endproperty
	a_otp_dummy: assert property (p_otp_dummy)
		else $error("wrong default OTP dummy count");

	property p_vlk_alen;
		@(posedge sclk_in) disable iff (cs_n_in)
		(st_q == ST_ADDR && op_q == OP_VLK_READ && $stable(four_l)) |->
		alen_q == (four_l ? ADDR_BYTES4 : ADDR_BYTES3);
	endproperty
	a_vlk_alen: assert property (p_vlk_alen)
		else $error("lock read address length wrong");

	property p_nvl_alen;
		@(posedge sclk_in) disable iff (cs_n_in)
		(st_q == ST_ADDR && op_q == OP_NVLK_READ) |-> alen_q == ADDR_BYTES4;
	endproperty
	a_nvl_alen: assert property (p_nvl_alen)
		else $error("nonvolatile lock read not four bytes");

	property p_disc_alen;
		@(posedge sclk_in) disable iff (cs_n_in)
		(st_q == ST_ADDR && op_q == OP_DISC_READ) |-> alen_q == ADDR_BYTES3;
	endproperty
	a_disc_alen: assert property (p_disc_alen)
		else $error("discovery read not three bytes");

	property p_gpr_dummy;
		@(posedge sclk_in) disable iff (cs_n_in)
		(st_q == ST_DUMMY && op_q == OP_GPR_READ) |-> dum_q == DUMMY_GPR;
	endproperty
	a_gpr_dummy: assert property (p_gpr_dummy)
		else $error("register read dummy count wrong");

	property p_gpr_zero;
		@(posedge sclk_in) disable iff (cs_n_in)
		(st_q == ST_DATA && op_q == OP_GPR_READ && load &&
		 cnt_q >= GPR_BYTES) |=> out_q == BYTE_ZERO;
	endproperty
	a_gpr_zero: assert property (p_gpr_zero)
		else $error("register read wrapped past end");

	property p_frz_single;
		@(posedge sclk_in) disable iff (cs_n_in)
		(st_q == ST_CMD && byte_done && byte_d == OP_FRZ_READ &&
		 lw != LINES_1) |=> s_ignoring;
	endproperty
	a_frz_single: assert property (p_frz_single)
		else $error("freeze read accepted on many lines");

	property p_ignore;
		@(posedge sclk_in) disable iff (cs_n_in)
		s_ignoring |=> s_ignoring ##1 s_ignoring;
	endproperty
	a_ignore: assert property (p_ignore)
		else $error("ignored frame resumed");

endmodule : fmcd_decoder

//--- verification/fmcd_host_model.sv
// Host-side serial flash controller model that frames commands
`timescale 1ns/100ps
module fmcd_host_model (
	input  wire logic [3:0] dq_in,
	output logic            sclk_out,
	output logic            cs_n_out,
	output logic      [3:0] host_d_out,
	output logic      [7:0] rx_byte_out,
	output logic            rx_tgl_out
);
	localparam time HALF = 32;

	initial begin
		sclk_out = 1'h0;
		cs_n_out = 1'h1;
		host_d_out = 4'h5;
		rx_byte_out = 8'h00;
		rx_tgl_out = 1'h0;
	end

	// Released lines keep changing so a stale value never looks valid
	task automatic tick();
		#HALF;
		sclk_out = 1'h1;
		#HALF;
		sclk_out = 1'h0;
	endtask : tick

	task automatic idle(input int n);
		cs_n_out = 1'h1;
		repeat (n) begin
			host_d_out = ~host_d_out;
			tick();
		end
	endtask : idle

	task automatic send_byte(input logic [7:0] b, input int w);
		for (int i = 7; i >= 0; i -= w) begin
			case (w)
				1: host_d_out = {~host_d_out[3:1], b[i]};
				2: host_d_out = {~host_d_out[3:2], b[i -: 2]};
				default: host_d_out = b[i -: 4];
			endcase
			tick();
		end
	endtask : send_byte

	task automatic recv_byte(input int w);
		logic [7:0] b;
		for (int i = 7; i >= 0; i -= w) begin
			host_d_out = ~host_d_out;
			#HALF;
			case (w)
				1: b[i] = dq_in[1];
				2: b[i -: 2] = dq_in[1:0];
				default: b[i -: 4] = dq_in;
			endcase
			sclk_out = 1'h1;
			#HALF;
			sclk_out = 1'h0;
		end
		rx_byte_out = b;
		rx_tgl_out = ~rx_tgl_out;
	endtask : recv_byte

	task automatic frame(input logic [7:0] op, input int w,
		input logic [31:0] addr, input int ab, input int dum,
		input logic [7:0] wd, input int wn, input int rn);
		#7;
		cs_n_out = 1'h0;
		send_byte(op, w);
		for (int k = ab - 1; k >= 0; k--) begin
			send_byte(addr[8*k +: 8], w);
		end
		repeat (dum) begin
			host_d_out = ~host_d_out;
			tick();
		end
		repeat (wn) send_byte(wd, w);
		repeat (rn) recv_byte(w);
		#HALF;
		idle(4);
	endtask : frame
endmodule : fmcd_host_model

//--- verification/fmcd_decoder_tb.sv
// Self-checking bench for the misc command decoder
`timescale 1ns/100ps
module fmcd_decoder_tb import fmcd_pkg::*; ;
	logic       clk_in;
	logic       rst_in;
	logic       dual_mode_in;
	logic [3:0] dummy_cfg_in;
	logic       sclk, cs_n, rx_tgl, q;
	logic       snap = 1'h0;
	logic [3:0] host_d, dout, oe, dq;
	logic [7:0] rx_byte;
	logic       four_byte, quad, deep_pd, freeze, wen;
	logic [7:0] rxq[$];
	logic [4:0] stq[$];
	int         failures, cmp_count, w, ab, seed;

	// Wire level from both drivers
	assign dq = (oe & dout) | (~oe & host_d);

	fmcd_decoder u_fmcd_decoder (
		.clk_in                   (clk_in),
		.rst_in                   (rst_in),
		.sclk_in                  (sclk),
		.cs_n_in                  (cs_n),
		.serial_data_lines_in     (dq),
		.serial_data_lines_out    (dout),
		.serial_data_lines_oe_out (oe),
		.dual_mode_in             (dual_mode_in),
		.dummy_cfg_in             (dummy_cfg_in),
		.four_byte_out            (four_byte),
		.quad_mode_out            (quad),
		.deep_pd_out              (deep_pd),
		.freeze_out               (freeze),
		.write_en_out             (wen)
	);

	fmcd_host_model u_fmcd_host_model (
		.dq_in       (dq),
		.sclk_out    (sclk),
		.cs_n_out    (cs_n),
		.host_d_out  (host_d),
		.rx_byte_out (rx_byte),
		.rx_tgl_out  (rx_tgl)
	);

	always #12.5 clk_in = ~clk_in;

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	always @(rx_tgl) begin
		if (rst_in === 1'h0) begin
			check(rx_byte, rxq.size() != 0 ? rxq.pop_front() : 8'hxx);
		end
	end

	always @(snap) begin
		check({3'h0, freeze, wen, deep_pd, quad, four_byte},
			{3'h0, stq.pop_front()});
	end

	function automatic logic [31:0] sa(input int s);
		logic [31:0] a;
		a = $random(seed);
		a[19:16] = 4'(s);
		return a;
	endfunction : sa

	task automatic cmd(input logic [7:0] op);
		u_fmcd_host_model.frame(op, w, 32'h0000_0000, 0, 0, 8'h00, 0, 0);
	endtask : cmd

	// Status settles within a few core cycles of the frame
	task automatic stat(input logic [4:0] e);
		stq.push_back(e);
		@(posedge clk_in);
		snap <= ~snap;
		@(posedge clk_in);
	endtask : stat

	task automatic rd(input logic [7:0] op, input logic [31:0] a,
		input int nab, input int dum, input int n, input logic [7:0] e);
		repeat (n) rxq.push_back(e);
		u_fmcd_host_model.frame(op, w, a, nab, dum, 8'h00, 0, n);
	endtask : rd

	// Upper data bits are random since only bit 0 counts
	task automatic lkw(input int s, input logic v);
		u_fmcd_host_model.frame(OP_VLK_WRITE, w, sa(s), ab, 0,
			{7'($random(seed)), v}, 1, 0);
	endtask : lkw

	task automatic done(input string name);
		$display("test %0s finished", name);
	endtask : done

	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : results

	initial begin
		#600000;
		failures++;
		results();
	end

	initial begin
		seed = 32'h0000_14ce;
		clk_in = 1'h0;
		rst_in = 1'h1;
		dual_mode_in = 1'h0;
		dummy_cfg_in = 4'h0;
		w = 1;
		ab = 3;
		// Link clock must run while reset is held
		fork
			repeat (12) @(posedge clk_in);
			u_fmcd_host_model.idle(4);
		join
		rst_in <= 1'h0;
		u_fmcd_host_model.idle(4);
		stat(5'h00);
		done("reset");
		for (int p = 0; p < 3; p++) begin
			@(posedge clk_in);
			dual_mode_in <= (p == 1);
			u_fmcd_host_model.idle(4);
			w = 1;
			if (p == 2) begin
				cmd(OP_QUAD_ENTER);
			end
			w = 1 << p;
			q = (p == 2);
			cmd(OP_ADDR4_ENTER);
			stat({3'h0, q, 1'h1});
			ab = 4;
			cmd(OP_WR_ENABLE);
			stat({3'h2, q, 1'h1});
			lkw(p + 1, 1'h1);
			stat({3'h0, q, 1'h1});
			rd(OP_VLK_READ, sa(p + 1), 4, 0, 2, 8'h01);
			cmd(OP_ADDR4_EXIT);
			stat({3'h0, q, 1'h0});
			ab = 3;
			rd(OP_VLK_READ, sa(p + 1), 3, 0, 1, 8'h01);
			rd(OP_VLK_READ, sa(p + 9), 3, 0, 1, 8'h00);
			rd(OP_OTP_READ, sa(0), 3, q ? 10 : 8, 1, 8'h00);
			cmd(OP_FRZ_READ);
			done("protocol");
		end
		cmd(OP_QUAD_EXIT);
		w = 1;
		stat(5'h00);
		lkw(1, 1'h0);
		rd(OP_VLK_READ, sa(1), 3, 0, 1, 8'h01);
		cmd(OP_WR_ENABLE);
		u_fmcd_host_model.frame(OP_NVLK_PROG, 1, sa(5), 4, 0, 8'h00, 0, 0);
		stat(5'h00);
		rd(OP_NVLK_READ, sa(5), 4, 0, 2, 8'h01);
		cmd(OP_WR_ENABLE);
		cmd(OP_NVLK_ERASE);
		rd(OP_NVLK_READ, sa(5), 4, 0, 1, 8'h00);
		cmd(OP_WR_ENABLE);
		stat(5'h08);
		cmd(OP_WR_DISABLE);
		stat(5'h00);
		cmd(OP_WR_ENABLE);
		u_fmcd_host_model.frame(OP_OTP_PROG, 1, sa(0), 3, 0, 8'h00, 1, 0);
		stat(5'h00);
		rd(OP_OTP_READ, sa(0), 3, 8, 2, 8'h00);
		cmd(OP_ADDR4_ENTER);
		rd(OP_DISC_READ, sa(0), 3, 8, 2, 8'h00);
		cmd(OP_ADDR4_EXIT);
		done("locks");
		u_fmcd_host_model.frame(8'h11, 1, 32'h0000_0000, 0, 0,
			OP_ADDR4_ENTER, 1, 0);
		stat(5'h00);
		cmd(OP_PD_ENTER);
		stat(5'h04);
		cmd(OP_ADDR4_ENTER);
		stat(5'h04);
		cmd(OP_PD_EXIT);
		stat(5'h00);
		done("power");
		@(posedge clk_in);
		dummy_cfg_in <= 4'($random(seed)) | 4'h1;
		for (int i = 0; i < 66; i++) begin
			rxq.push_back(i < 64 ? 8'(i) : 8'h00);
		end
		u_fmcd_host_model.frame(OP_GPR_READ, 1, 32'h0000_0000, 0, 8,
			8'h00, 0, 66);
		done("gpr");
		rd(OP_OTP_READ, sa(0), 3, dummy_cfg_in, 1, 8'h00);
		rd(OP_FRZ_READ, 32'h0000_0000, 0, 0, 1, 8'h00);
		cmd(OP_WR_ENABLE);
		cmd(OP_FRZ_SET);
		stat(5'h10);
		rd(OP_FRZ_READ, 32'h0000_0000, 0, 0, 2, 8'h01);
		cmd(OP_WR_ENABLE);
		lkw(2, 1'h0);
		stat(5'h18);
		rd(OP_VLK_READ, sa(2), 3, 0, 1, 8'h01);
		done("freeze");
		results();
	end
endmodule : fmcd_decoder_tb
